// [inc/intc_prio_cfg.svh]
`ifndef INTC_PRIO_CFG_SVH
`define INTC_PRIO_CFG_SVH

// Register byte offsets
`define OFS_MEASURE     8'h00
`define OFS_SERIAL3     8'h04
`define OFS_SERIAL4_ERR 8'h08
`define OFS_SERIAL4_TR  8'h0C
`define OFS_DISPLAY     8'h10
`define OFS_TEST_PORT   8'h14
`define OFS_TEST_STATUS 8'h18

// Field positions (least significant bit of each field)
`define LSB_MEASURE     4
`define LSB_S3_TX       12
`define LSB_S3_RX       8
`define LSB_S3_ERR      4
`define LSB_S4_ERR      12
`define LSB_S4_TX       4
`define LSB_S4_RX       0
`define LSB_DISPLAY     0
`define LSB_TEST_PORT   4
`define BIT_REQ_PEND    15
`define BIT_CAPTURE_SEL 13
`define LSB_NEW_LEVEL   8
`define LSB_VECTOR      0

// Reset value, and the priority that disables a source
`define PRIO_RESET      3'h4
`define PRIO_OFF        3'h0

// Vector numbers of the sources, lowest index first
`define VEC_MEASURE     7'h4_0
`define VEC_S3_TX       7'h4_1
`define VEC_S3_RX       7'h4_2
`define VEC_S3_ERR      7'h4_3
`define VEC_S4_ERR      7'h4_4
`define VEC_S4_TX       7'h4_5
`define VEC_S4_RX       7'h4_6
`define VEC_DISPLAY     7'h4_7
`define VEC_TEST_PORT   7'h4_8

`define NUM_SRC         9

`endif

// [inc/intc_prio_pkg.sv]
package intc_prio_pkg;
  // Register selector decoded from the bus address
  typedef enum logic [3:0] {
    REG_MEASURE  = 4'h0,
    REG_SERIAL3  = 4'h1,
    REG_S4_ERR   = 4'h2,
    REG_S4_TR    = 4'h3,
    REG_DISPLAY  = 4'h4,
    REG_TEST     = 4'h5,
    REG_STATUS   = 4'h6,
    REG_NONE     = 4'hF
  } reg_sel_t;

  // Bus slave state, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b01,
    BUS_WDATA = 2'b10
  } bus_state_t;

  typedef logic [2:0] prio_t;
endpackage

// [design/intc_prio.sv]
`timescale 1ns/1ns
`include "intc_prio_cfg.svh"

// Overview of operation
// - Three-bit priority, 111 highest, 001 lowest
// - Priority 000 disables the source
// - Reset sets every priority field to 4
// - Unimplemented bits read zero, ignore writes
// - Serial3 fields at 14-12, 10-8, 6-4
// - Serial4 error priority at bits 14-12
// - Serial4 transmit 6-4, receive 2-0
// - Measure unit priority at bits 6-4
// - Display priority at bits 2-0
// - Test port priority at bits 6-4
// - Bit 15 flags request held off by CPU
// - Capture select one shows highest pending vector
// - Capture select zero shows last acknowledged vector
// - Bits 11-8 show new CPU level
// - Vector field bits 6-0, values 0..127
// - Status bits hardware-only; select is software
// - Flag still set requests again at once
// - Trap levels 8-15 are never masked
module intc_prio
  import intc_prio_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Source flags and enables, from the flag and enable registers
  input  wire logic [8:0]  src_flag,
  input  wire logic [8:0]  src_enable,
  // Trap request from the core's trap logic
  input  wire logic        trap_req,
  input  wire logic [3:0]  trap_level,
  input  wire logic [6:0]  trap_vector,
  // Processor core side
  input  wire logic [3:0]  cpu_level,
  input  wire logic        cpu_ack,
  output logic             irq_req,
  output logic      [3:0]  irq_level,
  output logic      [6:0]  irq_vector
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address to register selector, shared by read and write paths
  function automatic reg_sel_t reg_index(input logic [7:0] a);
    case (a)
      `OFS_MEASURE:     reg_index = REG_MEASURE;
      `OFS_SERIAL3:     reg_index = REG_SERIAL3;
      `OFS_SERIAL4_ERR: reg_index = REG_S4_ERR;
      `OFS_SERIAL4_TR:  reg_index = REG_S4_TR;
      `OFS_DISPLAY:     reg_index = REG_DISPLAY;
      `OFS_TEST_PORT:   reg_index = REG_TEST;
      `OFS_TEST_STATUS: reg_index = REG_STATUS;
      default:          reg_index = REG_NONE;
    endcase
  endfunction

  // Vector number of each source; ascending with index for tie order
  function automatic logic [6:0] vec_of(input int unsigned i);
    case (i)
      0:       vec_of = `VEC_MEASURE;
      1:       vec_of = `VEC_S3_TX;
      2:       vec_of = `VEC_S3_RX;
      3:       vec_of = `VEC_S3_ERR;
      4:       vec_of = `VEC_S4_ERR;
      5:       vec_of = `VEC_S4_TX;
      6:       vec_of = `VEC_S4_RX;
      7:       vec_of = `VEC_DISPLAY;
      default: vec_of = `VEC_TEST_PORT;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  bus_state_t  bus_state;
  reg_sel_t    wr_sel;
  prio_t       prio [`NUM_SRC];
  logic        capture_sel;
  logic        request_pending;
  logic [3:0]  new_cpu_level;
  logic [6:0]  last_vector;
  logic [6:0]  pend_vector;
  logic [15:0] status_word;
  logic [15:0] next_rdata;
  logic        addr_phase;
  prio_t       best_lvl;
  logic [6:0]  best_vec;
  logic        best_hit;
  logic        next_req;
  logic [3:0]  next_level;
  logic [6:0]  next_vector;

  assign addr_phase = hsel && hready && htrans[1];

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY

  // Write data arrives one cycle after the address, so remember target
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_state <= BUS_IDLE;
      wr_sel    <= REG_NONE;
    end else begin
      case (bus_state)
        BUS_IDLE,
        BUS_WDATA: begin
          if (addr_phase && hwrite) begin
            bus_state <= BUS_WDATA;
            wr_sel    <= reg_index(haddr[7:0]);
          end else begin
            bus_state <= BUS_IDLE;
            wr_sel    <= REG_NONE;
          end
        end
        default: begin
          bus_state <= BUS_IDLE;
          wr_sel    <= REG_NONE;
        end
      endcase
    end
  end

  // Never stalls, never errors; an unmapped address reads zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Status word: only hardware moves bits 15, 11-8 and 6-0
  always_comb begin
    status_word = 16'h0000;
    status_word[`BIT_REQ_PEND] = request_pending;
    status_word[`BIT_CAPTURE_SEL] = capture_sel;
    status_word[`LSB_NEW_LEVEL +: 4] = new_cpu_level;
    // Selector picks live pending or last taken vector
    status_word[`LSB_VECTOR +: 7] = capture_sel ? pend_vector
                                                : last_vector;
  end

  // Read mux; absent bit positions stay zero
  always_comb begin
    next_rdata = 16'h0000;
    case (reg_index(haddr[7:0]))
      REG_MEASURE: next_rdata[`LSB_MEASURE +: 3] = prio[0];
      REG_SERIAL3: begin
        next_rdata[`LSB_S3_TX +: 3]  = prio[1];
        next_rdata[`LSB_S3_RX +: 3]  = prio[2];
        next_rdata[`LSB_S3_ERR +: 3] = prio[3];
      end
      REG_S4_ERR:  next_rdata[`LSB_S4_ERR +: 3] = prio[4];
      REG_S4_TR: begin
        next_rdata[`LSB_S4_TX +: 3] = prio[5];
        next_rdata[`LSB_S4_RX +: 3] = prio[6];
      end
      REG_DISPLAY: next_rdata[`LSB_DISPLAY +: 3] = prio[7];
      REG_TEST:    next_rdata[`LSB_TEST_PORT +: 3] = prio[8];
      REG_STATUS:  next_rdata = status_word;
      default:     next_rdata = 16'h0000;
    endcase
  end

  // Read data is captured at the address phase so it stands registered
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= {16'h0000, next_rdata};
    end else begin
      hrdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Priority fields

  // Only the documented field bits are stored, so others ignore writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < `NUM_SRC; i++) begin
        prio[i] <= `PRIO_RESET;
      end
    end else if (bus_state == BUS_WDATA) begin
      case (wr_sel)
        REG_MEASURE: prio[0] <= hwdata[`LSB_MEASURE +: 3];
        REG_SERIAL3: begin
          prio[1] <= hwdata[`LSB_S3_TX +: 3];
          prio[2] <= hwdata[`LSB_S3_RX +: 3];
          prio[3] <= hwdata[`LSB_S3_ERR +: 3];
        end
        REG_S4_ERR:  prio[4] <= hwdata[`LSB_S4_ERR +: 3];
        REG_S4_TR: begin
          prio[5] <= hwdata[`LSB_S4_TX +: 3];
          prio[6] <= hwdata[`LSB_S4_RX +: 3];
        end
        REG_DISPLAY: prio[7] <= hwdata[`LSB_DISPLAY +: 3];
        REG_TEST:    prio[8] <= hwdata[`LSB_TEST_PORT +: 3];
        default: ;
      endcase
    end
  end

  // Capture select is the only software-writable status bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      capture_sel <= 1'b0;
    end else if (bus_state == BUS_WDATA && wr_sel == REG_STATUS) begin
      capture_sel <= hwdata[`BIT_CAPTURE_SEL];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Arbitration

  // Strict greater-than keeps the lowest vector on equal levels
  always_comb begin
    best_lvl = `PRIO_OFF;
    best_vec = 7'h0_0;
    best_hit = 1'b0;
    for (int i = 0; i < `NUM_SRC; i++) begin
      if (src_flag[i] && src_enable[i] && prio[i] != `PRIO_OFF
          && prio[i] > best_lvl) begin
        best_lvl = prio[i];
        best_vec = vec_of(i);
        best_hit = 1'b1;
      end
    end
  end

  // Traps bypass the CPU level compare; user levels must beat it
  always_comb begin
    if (trap_req) begin
      next_req    = 1'b1;
      next_level  = trap_level;
      next_vector = trap_vector;
    end else begin
      // Re-evaluated every cycle, so a flag left set asks again
      next_req    = best_hit && ({1'b0, best_lvl} > cpu_level);
      next_level  = {1'b0, best_lvl};
      next_vector = best_vec;
    end
  end

  // Request port to the core
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_req    <= 1'b0;
      irq_level  <= 4'h0;
      irq_vector <= 7'h0_0;
    end else begin
      irq_req    <= next_req;
      irq_level  <= next_req ? next_level : 4'h0;
      irq_vector <= next_req ? next_vector : 7'h0_0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hardware status

  // Pending but held off because the CPU runs at or above its level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      request_pending <= 1'b0;
      pend_vector     <= 7'h0_0;
    end else begin
      request_pending <= best_hit && !trap_req
                         && ({1'b0, best_lvl} <= cpu_level);
      pend_vector     <= trap_req ? trap_vector : best_vec;
    end
  end

  // Acknowledge latches what the core actually took
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      new_cpu_level <= 4'h0;
      last_vector   <= 7'h0_0;
    end else if (cpu_ack && irq_req) begin
      new_cpu_level <= irq_level;
      last_vector   <= irq_vector;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_reset_level_four: assert property (
    $fell(rst) |-> prio[0] == `PRIO_RESET && prio[8] == `PRIO_RESET)
    else $error("priority field not at level 4 after reset");

  chk_user_above_cpu: assert property (
    irq_req && !$past(trap_req) |-> irq_level > $past(cpu_level))
    else $error("user request presented at or below cpu level");

  chk_disabled_silent: assert property (
    prio[0] == `PRIO_OFF && !trap_req
    |=> !(irq_req && irq_vector == `VEC_MEASURE))
    else $error("disabled source raised a request");

  chk_trap_unmasked: assert property (
    trap_req |=> irq_req && irq_level == $past(trap_level))
    else $error("trap request was masked");

  chk_pending_bit: assert property (
    best_hit && !trap_req && {1'b0, best_lvl} <= cpu_level
    |=> request_pending && !irq_req)
    else $error("held-off request not flagged");

  chk_ack_level: assert property (
    cpu_ack && irq_req |=> new_cpu_level == $past(irq_level)
                           && last_vector == $past(irq_vector))
    else $error("acknowledge did not latch level and vector");

  chk_vector_select: assert property (
    addr_phase && !hwrite && reg_index(haddr[7:0]) == REG_STATUS
    && !capture_sel |=> hrdata[6:0] == $past(last_vector))
    else $error("vector field not last acknowledged");

  chk_vector_pending: assert property (
    addr_phase && !hwrite && reg_index(haddr[7:0]) == REG_STATUS
    && capture_sel |=> hrdata[6:0] == $past(pend_vector))
    else $error("vector field not highest pending");

  chk_write_lands: assert property (
    bus_state == BUS_WDATA && wr_sel == REG_MEASURE
    |=> prio[0] == $past(hwdata[6:4]))
    else $error("measure unit priority write lost");

  chk_request_cleared: assert property (
    !best_hit && !trap_req |=> !irq_req && irq_level == 4'h0)
    else $error("request without an eligible source");

  chk_read_reserved: assert property (
    addr_phase && !hwrite && reg_index(haddr[7:0]) == REG_SERIAL3
    |=> hrdata[31:15] == 17'h0_0000 && hrdata[11] == 1'b0
        && hrdata[7] == 1'b0 && hrdata[3:0] == 4'h0)
    else $error("unimplemented bits read nonzero");

  chk_tie_lowest: assert property (
    src_flag[1] && src_enable[1] && src_flag[2] && src_enable[2]
    && prio[1] == prio[2] && prio[1] != `PRIO_OFF && !trap_req
    |=> irq_vector != `VEC_S3_RX)
    else $error("tie not resolved to lowest vector");

  cov_user_request: cover property (!trap_req ##1 irq_req);
  cov_trap_request: cover property (trap_req ##1 irq_req);
  cov_held_off:     cover property (request_pending);
  cov_ack_taken:    cover property (cpu_ack && irq_req);
  cov_tie_break:    cover property (src_flag[1] && src_flag[2]
    && src_enable[1] && src_enable[2] ##1 irq_vector == `VEC_S3_TX);

endmodule

// [verif/cpu_core_model.sv]
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Processor core stand-in: takes presented requests and raises its own level
module cpu_core_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Request from the controller
  input  wire logic       irq_req,
  input  wire logic [3:0] irq_level,
  // Bench control of the core
  input  wire logic       ack_en,
  input  wire logic       nest_off,
  input  wire logic       level_load,
  input  wire logic [3:0] level_val,
  // Core state seen by the controller
  output logic      [3:0] cpu_level,
  output logic            cpu_ack
);
  logic in_handler;

  // Accept only while a request is presented, so no stray acknowledge;
  // with nesting off a core already in a handler takes nothing more
  assign cpu_ack = ack_en & irq_req & ~(nest_off & in_handler);

  // A taken request enters a handler; a level load models its return
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      in_handler <= 1'b0;
    end else if (level_load) begin
      in_handler <= 1'b0;
    end else if (cpu_ack) begin
      in_handler <= 1'b1;
    end
  end

  // Entering a handler lifts the core to the accepted level; the bench
  // loads a level to model a return or a software mask change
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cpu_level <= 4'h0;
    end else if (level_load) begin
      cpu_level <= level_val;
    end else if (cpu_ack) begin
      cpu_level <= irq_level;
    end
  end
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ns
`include "intc_prio_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module tb_top;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [8:0]  src_flag = 9'h000;
  logic [8:0]  src_enable = 9'h000;
  logic        trap_req = 1'b0;
  logic [3:0]  trap_level = 4'h0;
  logic [6:0]  trap_vector = 7'h00;
  logic [3:0]  cpu_level;
  logic        cpu_ack;
  logic        irq_req;
  logic [3:0]  irq_level;
  logic [6:0]  irq_vector;
  logic        ack_en = 1'b0;
  logic        nest_off = 1'b0;
  logic        level_load = 1'b0;
  logic [3:0]  level_val = 4'h0;
  logic [31:0] rd;
  int          errors = 0;
  int          checks = 0;

  localparam logic [7:0] OFS_T [0:6] = '{`OFS_MEASURE, `OFS_SERIAL3,
    `OFS_SERIAL4_ERR, `OFS_SERIAL4_TR, `OFS_DISPLAY, `OFS_TEST_PORT,
    `OFS_TEST_STATUS};
  localparam logic [31:0] RST_T [0:6] = '{32'h0000_0040, 32'h0000_4440,
    32'h0000_4000, 32'h0000_0044, 32'h0000_0004, 32'h0000_0040,
    32'h0000_0000};
  localparam logic [31:0] MSK_T [0:6] = '{32'h0000_0070, 32'h0000_7770,
    32'h0000_7000, 32'h0000_0077, 32'h0000_0007, 32'h0000_0070,
    32'h0000_2000};

  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;

  intc_prio u_dut (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp),
    .src_flag(src_flag), .src_enable(src_enable), .trap_req(trap_req),
    .trap_level(trap_level), .trap_vector(trap_vector),
    .cpu_level(cpu_level), .cpu_ack(cpu_ack), .irq_req(irq_req),
    .irq_level(irq_level), .irq_vector(irq_vector)
  );

  cpu_core_model u_core (
    .clk_sys(clk_sys), .rst(rst), .irq_req(irq_req), .irq_level(irq_level),
    .ack_en(ack_en), .nest_off(nest_off), .level_load(level_load),
    .level_val(level_val),
    .cpu_level(cpu_level), .cpu_ack(cpu_ack)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Verdict in one place, reached by the main sequence or a timeout
  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check_irq(input logic r, input logic [3:0] l,
                           input logic [6:0] v);
    repeat (3) @(posedge clk_sys);
    #1;
    check({20'h0_0000, irq_req, irq_level, irq_vector},
          {20'h0_0000, r, l, v});
  endtask

  // Bounded wait for the slave's ready; running out ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      errors++;
      end_of_test;
    end
  endtask

  // One single word transfer; read data is taken at the data phase edge
  task automatic bus_xfer(input logic wr, input logic [7:0] a,
                          input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready;
    rdv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus_xfer(1'b1, a, d, dummy);
  endtask

  task automatic set_level(input logic [3:0] v);
    @(posedge clk_sys);
    level_load <= 1'b1;
    level_val  <= v;
    @(posedge clk_sys);
    level_load <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    nest_off <= 1'b1;
    // Reset values, then all-ones writes expose the implemented fields
    for (int i = 0; i < 7; i++) begin
      bus_xfer(1'b0, OFS_T[i], 32'h0, rd);
      check(rd, RST_T[i]);
      wr(OFS_T[i], 32'hFFFF_FFFF);
      bus_xfer(1'b0, OFS_T[i], 32'h0, rd);
      check(rd, MSK_T[i]);
    end
    wr(8'h1C, 32'hFFFF_FFFF);
    bus_xfer(1'b0, 8'h1C, 32'h0, rd);
    check(rd, 32'h0000_0000);
    wr(`OFS_SERIAL3, 32'h0000_3510);
    bus_xfer(1'b0, `OFS_SERIAL3, 32'h0, rd);
    check(rd, 32'h0000_3510);
    // Setup order: priority, level, flag cleared, enable, then flag set
    wr(`OFS_TEST_STATUS, 32'h0000_0000);
    wr(`OFS_SERIAL3, 32'h0000_0000);
    wr(`OFS_MEASURE, 32'h0000_0050);
    set_level(4'h3);
    @(posedge clk_sys);
    src_flag <= 9'h000;
    @(posedge clk_sys);
    src_enable <= 9'h001;
    @(posedge clk_sys);
    src_flag <= 9'h001;
    check_irq(1'b1, 4'h5, `VEC_MEASURE);
    // Acknowledge lifts the core to 5; the flag stays, so it is held off
    @(posedge clk_sys);
    ack_en <= 1'b1;
    @(posedge clk_sys);
    ack_en <= 1'b0;
    check_irq(1'b0, 4'h0, 7'h00);
    bus_xfer(1'b0, `OFS_TEST_STATUS, 32'h0, rd);
    check(rd, 32'h0000_8540);
    set_level(4'h3);
    check_irq(1'b1, 4'h5, `VEC_MEASURE);
    // Priority 000 silences the source
    set_level(4'h0);
    wr(`OFS_MEASURE, 32'h0000_0000);
    check_irq(1'b0, 4'h0, 7'h00);
    // Two sources at one shared level: lowest vector wins
    wr(`OFS_SERIAL3, 32'h0000_6600);
    @(posedge clk_sys);
    src_flag <= 9'h006;
    src_enable <= 9'h006;
    check_irq(1'b1, 4'h6, `VEC_S3_TX);
    wr(`OFS_TEST_STATUS, 32'h0000_2000);
    repeat (2) @(posedge clk_sys);
    bus_xfer(1'b0, `OFS_TEST_STATUS, 32'h0, rd);
    check(rd, 32'h0000_2541);
    @(posedge clk_sys);
    src_enable <= 9'h004;
    check_irq(1'b1, 4'h6, `VEC_S3_RX);
    // Core at level 7 masks users but not a trap
    set_level(4'h7);
    check_irq(1'b0, 4'h0, 7'h00);
    @(posedge clk_sys);
    trap_req <= 1'b1;
    trap_level <= 4'h9;
    trap_vector <= 7'h05;
    check_irq(1'b1, 4'h9, 7'h05);
    check({31'h0, hresp}, 32'h0000_0000);
    end_of_test;
  end
endmodule
